// file: src/prm_pkg.sv
// Shared constants, types and helpers for the privileged register move unit.
package prm_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SR_W = 16;
  localparam int unsigned LIST_W = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned CSEL_W = 2;
  localparam int unsigned CTRL_NUM = 4;
  localparam int unsigned SUP_BIT = 13;
  localparam logic [SR_W-1:0] SR_RESET = 16'h2700;
  localparam logic [SR_W-1:0] CCR_MASK = 16'h001F;
  localparam logic [DATA_W-1:0] USP_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] WORD_STEP = 32'h00000004;
  localparam logic [IDX_W-1:0] ADDR_REG_BASE = 4'h8;

  typedef enum logic [2:0] {
    OP_TO_CCR,
    OP_FROM_SR,
    OP_TO_SR,
    OP_USP,
    OP_CTRL,
    OP_MULTI
  } prm_op_t;

  // Index of the lowest set bit of a register list, zero when the list is empty.
  function automatic logic [IDX_W-1:0] prm_lowest(input logic [LIST_W-1:0] list);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = LIST_W - 1; i >= 0; i--) begin
      if (list[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : prm_lowest
endpackage : prm_pkg

// file: src/prm_walk_if.sv
// Handshake between the move unit and its register list walker.
`timescale 1ns/10ps
interface prm_walk_if;
  import prm_pkg::*;
  logic load;
  logic [LIST_W-1:0] list;
  logic advance;
  logic [IDX_W-1:0] idx;
  logic last;
  modport walker (input load, input list, input advance, output idx, output last);
  modport user (output load, output list, output advance, input idx, input last);
endinterface : prm_walk_if

// file: src/prm_list_walker.sv
// Steps through the set bits of a register list, lowest index first.
`timescale 1ns/10ps
module prm_list_walker
  import prm_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic reset, // Synchronous reset, active high.
  prm_walk_if.walker walk // Load, advance and current index.
);
  logic [LIST_W-1:0] mask_reg;
  logic [LIST_W-1:0] mask_next;
  logic [IDX_W-1:0] idx_reg;
  wire logic [LIST_W-1:0] remain = mask_reg & ~(LIST_W'(1) << idx_reg);

  assign mask_next = walk.load ? walk.list : (walk.advance ? remain : mask_reg);
  assign walk.idx = idx_reg;
  assign walk.last = (remain == '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= '0;
      idx_reg <= '0;
    end else begin
      mask_reg <= mask_next;
      idx_reg <= prm_lowest(mask_next);
    end
  end
endmodule : prm_list_walker

// file: src/prm_privileged_register_moves.sv
// Executes condition code, status word, user stack pointer, control and multiple register moves.
//
// Behaviour
// - Condition code load never checks privilege.
// - Status word read only when supervisor, else trap.
// - Status word write only when supervisor, else trap.
// - User stack pointer move supervisor only, else trap.
// - User stack pointer reads target address registers only; writes load cmd_src whatever cmd_reg names.
// - Control register move supervisor only, else trap.
// - Multiple move transfers every listed register.
`timescale 1ns/10ps
module prm_privileged_register_moves
  import prm_pkg::*;
(
  input wire logic clk, // Core clock, 25 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic cmd_valid, // Instruction offered this cycle.
  input wire prm_op_t cmd_op, // Which move to execute.
  input wire logic cmd_dir, // 1: into the special register or memory load; 0: out of it.
  input wire logic [IDX_W-1:0] cmd_reg, // General register number of the operand.
  input wire logic [CSEL_W-1:0] cmd_csel, // Selected control register.
  input wire logic [DATA_W-1:0] cmd_src, // Evaluated source operand.
  input wire logic [LIST_W-1:0] cmd_list, // Register list of a multiple move.
  input wire logic [DATA_W-1:0] cmd_addr, // Memory operand address of a multiple move.
  output logic cmd_ready, // Unit can take an instruction.
  output logic trap_pulse, // Privilege violation, one cycle.
  output logic dst_valid, // Destination operand valid, one cycle.
  output logic [DATA_W-1:0] dst_data, // Destination operand value.
  output logic reg_wr_en, // General register write strobe.
  output logic [IDX_W-1:0] reg_wr_idx, // General register written.
  output logic [DATA_W-1:0] reg_wr_data, // Value written.
  output logic [IDX_W-1:0] reg_rd_idx, // General register read during a store.
  input wire logic [DATA_W-1:0] reg_rd_data, // Value of that register, same cycle.
  output logic mem_req, // Memory request, held until acknowledged.
  output logic mem_we, // Memory request is a write.
  output logic [DATA_W-1:0] mem_addr, // Memory address.
  output logic [DATA_W-1:0] mem_wdata, // Memory write data.
  input wire logic mem_ack, // Memory completes the request.
  input wire logic [DATA_W-1:0] mem_rdata, // Memory read data with the acknowledge.
  output logic [SR_W-1:0] status_word, // Current status word register.
  output logic [DATA_W-1:0] user_stack_pointer // Current user stack pointer.
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} prm_state_t;

  prm_state_t state_reg, state_next;
  logic [SR_W-1:0] sr_reg, sr_next;
  logic [DATA_W-1:0] usp_reg, usp_next;
  logic [DATA_W-1:0] ctrl_reg [CTRL_NUM];
  logic [DATA_W-1:0] addr_reg, addr_next;
  logic load_dir_reg;
  logic trap_reg, dst_valid_reg, reg_wr_en_reg, mem_req_reg, mem_we_reg;
  logic [DATA_W-1:0] dst_data_reg, reg_wr_data_reg, mem_wdata_reg;
  logic [IDX_W-1:0] reg_wr_idx_reg;

  prm_walk_if walk ();

  prm_list_walker u_walker (
    .clk(clk),
    .reset(reset),
    .walk(walk.walker)
  );

  wire logic supervisor = sr_reg[SUP_BIT];
  wire logic accept = cmd_valid && (state_reg == ST_IDLE);
  wire logic privileged = (cmd_op == OP_FROM_SR) || (cmd_op == OP_TO_SR) || (cmd_op == OP_USP) ||
                          (cmd_op == OP_CTRL);
  wire logic trap_now = accept && privileged && !supervisor;
  wire logic exec = accept && !trap_now;
  wire logic list_ack = (state_reg == ST_WAIT) && mem_ack;
  wire logic list_end = list_ack && walk.last;
  wire logic [IDX_W-1:0] usp_an_idx = ADDR_REG_BASE | {1'b0, cmd_reg[IDX_W-2:0]};

  wire logic wr_ccr = exec && (cmd_op == OP_TO_CCR);
  wire logic wr_sr = exec && (cmd_op == OP_TO_SR);
  wire logic wr_usp = exec && (cmd_op == OP_USP) && cmd_dir;
  wire logic wr_ctrl = exec && (cmd_op == OP_CTRL) && cmd_dir;
  wire logic start_list = exec && (cmd_op == OP_MULTI) && (cmd_list != '0);

  assign sr_next = wr_sr ? cmd_src[SR_W-1:0] :
                   (wr_ccr ? ((sr_reg & ~CCR_MASK) | (cmd_src[SR_W-1:0] & CCR_MASK)) : sr_reg);
  assign usp_next = wr_usp ? cmd_src : usp_reg;
  assign addr_next = start_list ? cmd_addr : (list_ack ? addr_reg + WORD_STEP : addr_reg);

  assign walk.load = start_list;
  assign walk.list = cmd_list;
  assign walk.advance = list_ack;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_list) begin
          state_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (list_end) begin
          state_next = ST_IDLE;
        end else if (list_ack) begin
          state_next = ST_ISSUE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      sr_reg <= SR_RESET;
      usp_reg <= USP_RESET;
      addr_reg <= '0;
      load_dir_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sr_reg <= sr_next;
      usp_reg <= usp_next;
      addr_reg <= addr_next;
      load_dir_reg <= start_list ? cmd_dir : load_dir_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < CTRL_NUM; i++) begin
        ctrl_reg[i] <= CTRL_RESET;
      end
    end else if (wr_ctrl) begin
      ctrl_reg[cmd_csel] <= cmd_src;
    end
  end

  // Register write port: USER_STACK_POINTER and control reads on accept, list loads on acknowledge.
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_wr_en_reg <= 1'b0;
      reg_wr_idx_reg <= '0;
      reg_wr_data_reg <= '0;
    end else if (list_ack && load_dir_reg) begin
      reg_wr_en_reg <= 1'b1;
      reg_wr_idx_reg <= walk.idx;
      reg_wr_data_reg <= mem_rdata;
    end else if (exec && (cmd_op == OP_USP) && !cmd_dir) begin
      reg_wr_en_reg <= 1'b1;
      reg_wr_idx_reg <= usp_an_idx;
      reg_wr_data_reg <= usp_reg;
    end else if (exec && (cmd_op == OP_CTRL) && !cmd_dir) begin
      reg_wr_en_reg <= 1'b1;
      reg_wr_idx_reg <= cmd_reg;
      reg_wr_data_reg <= ctrl_reg[cmd_csel];
    end else begin
      reg_wr_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trap_reg <= 1'b0;
      dst_valid_reg <= 1'b0;
      dst_data_reg <= '0;
    end else begin
      trap_reg <= trap_now;
      dst_valid_reg <= exec && (cmd_op == OP_FROM_SR);
      dst_data_reg <= (exec && (cmd_op == OP_FROM_SR)) ? {{(DATA_W-SR_W){1'b0}}, sr_reg} : dst_data_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= '0;
    end else if (state_reg == ST_ISSUE) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= !load_dir_reg;
      mem_wdata_reg <= reg_rd_data;
    end else if (list_ack) begin
      mem_req_reg <= 1'b0;
    end
  end

  assign cmd_ready = (state_reg == ST_IDLE);
  assign trap_pulse = trap_reg;
  assign dst_valid = dst_valid_reg;
  assign dst_data = dst_data_reg;
  assign reg_wr_en = reg_wr_en_reg;
  assign reg_wr_idx = reg_wr_idx_reg;
  assign reg_wr_data = reg_wr_data_reg;
  assign reg_rd_idx = walk.idx;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign status_word = sr_reg;
  assign user_stack_pointer = usp_reg;

  logic [4:0] want_cnt, done_cnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      want_cnt <= '0;
      done_cnt <= '0;
    end else if (start_list) begin
      want_cnt <= 5'($countones(cmd_list));
      done_cnt <= '0;
    end else if (list_ack) begin
      done_cnt <= done_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ccr_no_check: assert property (accept && cmd_op == OP_TO_CCR |=> !trap_pulse &&
    (status_word & CCR_MASK) == ($past(cmd_src[SR_W-1:0]) & CCR_MASK)) else $error("ccr load wrong");
  a_sr_read_copy: assert property (accept && cmd_op == OP_FROM_SR |=>
    (dst_valid == $past(supervisor)) && (trap_pulse != $past(supervisor))) else $error("sr read wrong");
  a_sr_write_guard: assert property (accept && cmd_op == OP_TO_SR && !supervisor |=>
    trap_pulse && $stable(status_word)) else $error("sr write not blocked");
  a_sr_write_load: assert property (accept && cmd_op == OP_TO_SR && supervisor |=>
    status_word == $past(cmd_src[SR_W-1:0])) else $error("sr write lost");
  a_usp_user_trap: assert property (accept && cmd_op == OP_USP && !supervisor |=>
    trap_pulse && !reg_wr_en && $stable(user_stack_pointer)) else $error("usp not trapped");
  a_usp_addr_only: assert property (accept && cmd_op == OP_USP && supervisor && !cmd_dir |=>
    reg_wr_en && reg_wr_idx[IDX_W-1]) else $error("usp target not address register");
  a_ctrl_user_trap: assert property (accept && cmd_op == OP_CTRL && !supervisor |=>
    trap_pulse && !reg_wr_en) else $error("control move not trapped");
  a_ctrl_trap_keep: assert property (accept && cmd_op == OP_CTRL && !supervisor |=>
    $stable(ctrl_reg[0]) && $stable(ctrl_reg[1]) && $stable(ctrl_reg[2]) && $stable(ctrl_reg[3]))
    else $error("control register written during trap");
  a_list_all_done: assert property (list_end |=> done_cnt == want_cnt && cmd_ready)
    else $error("list count mismatch");
  a_trap_no_write: assert property (trap_pulse |-> !reg_wr_en && !mem_req && !dst_valid)
    else $error("write during trap");

  c_sr_write: cover property (accept && cmd_op == OP_TO_SR && supervisor);
  c_user_trap: cover property (trap_pulse);
  c_list_three: cover property (list_end && want_cnt == 5'h03);
  c_ctrl_read: cover property (accept && cmd_op == OP_CTRL && supervisor && !cmd_dir);
endmodule : prm_privileged_register_moves

// file: verif/testbench.sv
// Self-checking testbench for the privileged register move unit.
`timescale 1ns/10ps
module testbench;
  import prm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  prm_op_t cmd_op = OP_TO_CCR;
  logic cmd_dir = 1'b0;
  logic [3:0] cmd_reg = 4'h0;
  logic [1:0] cmd_csel = 2'h0;
  logic [31:0] cmd_src = 32'h0;
  logic [15:0] cmd_list = 16'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic mem_ack = 1'b0;
  logic [31:0] mem_rdata = 32'h0;
  logic cmd_ready, trap_pulse, dst_valid, reg_wr_en, mem_req, mem_we;
  logic [31:0] dst_data, reg_wr_data, mem_addr, mem_wdata, user_stack_pointer, reg_rd_data;
  logic [3:0] reg_wr_idx, reg_rd_idx;
  logic [15:0] status_word;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  // The register file answers with a value that names the register read.
  assign reg_rd_data = {28'hC0DE5A0, reg_rd_idx};

  prm_privileged_register_moves prm_privileged_register_moves_i (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_dir(cmd_dir),
    .cmd_reg(cmd_reg), .cmd_csel(cmd_csel), .cmd_src(cmd_src), .cmd_list(cmd_list),
    .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .trap_pulse(trap_pulse), .dst_valid(dst_valid),
    .dst_data(dst_data), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
    .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .status_word(status_word), .user_stack_pointer(user_stack_pointer));

  always #20 clk = ~clk;

  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Offers one instruction and returns just after the edge that takes it, still offering.
  task automatic op(input prm_op_t o, input logic d, input logic [3:0] r, input logic [1:0] cs,
                    input logic [31:0] s);
    cmd_op = o;
    cmd_dir = d;
    cmd_reg = r;
    cmd_csel = cs;
    cmd_src = s;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask : op

  task automatic idle();
    cmd_valid = 1'b0;
  endtask : idle

  task automatic t_super();
    op(OP_TO_CCR, 1'b0, 4'h0, 2'h0, 32'hFFFF_FFE3);
    chk("ccr_sup", 32'h2703, status_word);
    op(OP_FROM_SR, 1'b0, 4'h0, 2'h0, 32'h0);
    chk("rd_valid", 32'h1, dst_valid);
    chk("rd_data", 32'h0000_2703, dst_data);
    op(OP_TO_SR, 1'b0, 4'h0, 2'h0, 32'h0000_2715);
    chk("sr_wr", 32'h2715, status_word);
    op(OP_USP, 1'b1, 4'h2, 2'h0, 32'h1234_5678);
    chk("usp_wr", 32'h1234_5678, user_stack_pointer);
    op(OP_USP, 1'b0, 4'h3, 2'h0, 32'h0);
    chk("usp_rd_en", 32'h1, reg_wr_en);
    chk("usp_rd_idx", 32'hB, reg_wr_idx);
    chk("usp_rd_data", 32'h1234_5678, reg_wr_data);
    op(OP_CTRL, 1'b1, 4'h0, 2'h2, 32'hCAFE_0001);
    op(OP_CTRL, 1'b0, 4'h5, 2'h2, 32'h0);
    chk("ctl_idx", 32'h5, reg_wr_idx);
    chk("ctl_data", 32'hCAFE_0001, reg_wr_data);
    op(OP_CTRL, 1'b0, 4'h6, 2'h1, 32'h0);
    chk("ctl_other", 32'h0, reg_wr_data);
  endtask : t_super

  task automatic t_multi(input logic d, input logic [15:0] list, input logic [31:0] a);
    int k;
    int n;
    k = 0;
    cmd_list = list;
    cmd_addr = a;
    op(OP_MULTI, d, 4'h0, 2'h0, 32'h0);
    idle();
    for (int i = 0; i < 16; i++) begin
      if (list[i]) begin
        n = 0;
        while (mem_req !== 1'b1 && n < 20) begin
          @(posedge clk);
          #1;
          n++;
        end
        chk("m_addr", a + 32'(4 * k), mem_addr);
        chk("m_we", {31'h0, ~d}, mem_we);
        if (!d) begin
          chk("m_rd_idx", 32'(i), reg_rd_idx);
          chk("m_wdata", {28'hC0DE5A0, 4'(i)}, mem_wdata);
        end
        repeat (2) @(posedge clk);
        #1;
        chk("m_hold", 32'h1, mem_req);
        mem_ack = 1'b1;
        mem_rdata = 32'h5500_0000 + 32'(i);
        @(posedge clk);
        #1;
        mem_ack = 1'b0;
        chk("m_req_off", 32'h0, mem_req);
        if (d) begin
          chk("m_ld_en", 32'h1, reg_wr_en);
          chk("m_ld_idx", 32'(i), reg_wr_idx);
          chk("m_ld_data", 32'h5500_0000 + 32'(i), reg_wr_data);
        end
        k++;
      end
    end
    n = 0;
    while (cmd_ready !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("m_done", 32'h1, cmd_ready);
    chk("m_req_idle", 32'h0, mem_req);
  endtask : t_multi

  task automatic t_user();
    prm_op_t ops[4];
    ops = '{OP_FROM_SR, OP_TO_SR, OP_USP, OP_CTRL};
    op(OP_TO_SR, 1'b0, 4'h0, 2'h0, 32'h0000_0005);
    op(OP_TO_CCR, 1'b0, 4'h0, 2'h0, 32'h0000_001A);
    chk("ccr_user", 32'h001A, status_word);
    chk("ccr_notrap", 32'h0, trap_pulse);
    for (int d = 0; d < 2; d++) begin
      for (int j = 0; j < 4; j++) begin
        op(ops[j], d[0], 4'h9, 2'h2, 32'h0000_2700);
        chk("trap", 32'h1, trap_pulse);
        chk("no_dst", 32'h0, dst_valid);
        chk("no_wr", 32'h0, reg_wr_en);
        chk("sr_kept", 32'h001A, status_word);
        chk("usp_kept", 32'h1234_5678, user_stack_pointer);
      end
    end
    idle();
    @(posedge clk);
    #1;
    chk("trap_end", 32'h0, trap_pulse);
  endtask : t_user

  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("sr_reset", 32'h2700, status_word);
    chk("usp_reset", 32'h0, user_stack_pointer);
    chk("ready_reset", 32'h1, cmd_ready);
    t_super();
    t_multi(1'b0, 16'h800A, 32'h0000_1000);
    t_multi(1'b1, 16'h0104, 32'h0000_2000);
    t_multi(1'b0, 16'h0000, 32'h0000_3000);
    t_user();
    final_report();
  end
endmodule : testbench
